// file: design/scdluc_pkg.sv
package scdluc_pkg;
    // Channel organisation
    localparam int NUM_CH = 6;
    localparam int NUM_PAIR = 3;
    localparam int CODE_W = 12;
    localparam int LO_W = 8;
    localparam int HI_W = 4;
    localparam int CH_STRIDE = 2;

    // Register index layout inside the sixteen-location window
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 4;
    localparam int SEL_LSB = 6;
    localparam int SEL_W = 6;
    localparam int ADDR_TOP = 12;
    localparam logic [IDX_W-1:0] DAC_LAST_IDX = 4'hB;
    localparam logic [IDX_W-1:0] UPD_LAST_IDX = 4'hC;

    // Base selection that gives a window at 300H
    localparam logic [SEL_W-1:0] FACTORY_BASE_SEL = 6'h30;

    // Strap bundle layout
    localparam int STRAP_W = 11;
    localparam int STRAP_SEL_LSB = 0;
    localparam int STRAP_WAIT = 6;
    localparam int STRAP_ZERO = 7;
    localparam int STRAP_PAIR_LSB = 8;

    // Values after reset
    localparam logic [STRAP_W-1:0] STRAP_RST = 11'h000;
    localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
    localparam logic [LO_W-1:0] LO_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h00000000;
    localparam logic HOLD_RST = 1'b1;

    // Bus answer phase
    typedef enum logic [1:0] {
        SCDLUC_IDLE,
        SCDLUC_WAIT,
        SCDLUC_ANSWER
    } scdluc_phase_e;
endpackage

// file: design/scdluc_top.sv
// Behaviour
// - Low byte then high byte; output waits for high
// - Three pairs, one mode strap per pair
// - Simultaneous pairs update on read of 0..C
// - Window base from six switches against A9..A4
// - Optional single wait state, only for board
// - Zero power-up hold until high write, read
// - Low eight and high four bit locations
// - Sixteen locations, digital I/O takes last four
`timescale 1ns/1ps
module scdluc_top
    import scdluc_pkg::*;
(
    input wire logic CLOCK_IN, // 40 MHz clock
    input wire logic RESETN_IN, // Async reset, active low
    input wire logic PSEL_IN, // APB select
    input wire logic PENABLE_IN, // APB enable
    input wire logic PWRITE_IN, // APB direction, high for write
    input wire logic [31:0] PADDR_IN, // APB byte address
    input wire logic [31:0] PWDATA_IN, // APB write data
    input wire logic [3:0] PSTRB_IN, // APB byte strobes
    output logic [31:0] PRDATA_OUT, // APB read data
    output logic PREADY_OUT, // APB ready
    output logic PSLVERR_OUT, // APB error, address outside window
    input wire logic [scdluc_pkg::SEL_W-1:0] BASE_SWITCH_IN, // Base switch, A9..A4
    input wire logic WAIT_EN_IN, // Wait state strap
    input wire logic ZERO_POWERUP_IN, // High: zero hold, low: no hold, output follows output stage
    input wire logic [scdluc_pkg::NUM_PAIR-1:0] SIMUL_PAIR_IN, // High: pair simultaneous
    output logic [scdluc_pkg::CODE_W-1:0] DAC0_CODE_OUT, // Channel 0 output code
    output logic [scdluc_pkg::CODE_W-1:0] DAC1_CODE_OUT, // Channel 1 output code
    output logic [scdluc_pkg::CODE_W-1:0] DAC2_CODE_OUT, // Channel 2 output code
    output logic [scdluc_pkg::CODE_W-1:0] DAC3_CODE_OUT, // Channel 3 output code
    output logic [scdluc_pkg::CODE_W-1:0] DAC4_CODE_OUT, // Channel 4 output code
    output logic [scdluc_pkg::CODE_W-1:0] DAC5_CODE_OUT, // Channel 5 output code
    output logic [scdluc_pkg::NUM_CH-1:0] DAC_LOAD_OUT // Output stage load strobes
);
    import scdluc_pkg::*;

    logic [STRAP_W-1:0] strap_meta_reg;
    logic [STRAP_W-1:0] strap_sync_reg;
    logic [SEL_W-1:0] base_sel;
    logic wait_en;
    logic zero_mode;
    logic [NUM_PAIR-1:0] simul_pair;
    scdluc_phase_e phase_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic setup;
    logic done;
    logic [IDX_W-1:0] idx;
    logic bus_hit;
    logic wr_lo_byte;
    logic upd_rd;
    logic hold_reg;
    logic hold_next;
    logic armed_reg;
    logic any_hi_wr;
    logic [LO_W-1:0] lo_reg [NUM_CH];
    logic [CODE_W-1:0] input_reg [NUM_CH];
    logic [CODE_W-1:0] latched_reg [NUM_CH];
    logic [CODE_W-1:0] latched_next [NUM_CH];
    logic [CODE_W-1:0] code_out_reg [NUM_CH];
    logic [NUM_CH-1:0] load_reg;
    logic [NUM_CH-1:0] hi_wr;

    // Address lies in the switch-selected window, word aligned
    function automatic logic in_window(input logic [31:0] addr, input logic [SEL_W-1:0] sel);
        in_window = (addr[31:ADDR_TOP] == '0) && (addr[SEL_LSB +: SEL_W] == sel)
            && (addr[IDX_LSB-1:0] == '0);
    endfunction

    // Straps come from board jumpers and pass two flip-flops
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            strap_meta_reg <= STRAP_RST;
            strap_sync_reg <= STRAP_RST;
        end else begin
            strap_meta_reg <= {SIMUL_PAIR_IN, ZERO_POWERUP_IN, WAIT_EN_IN, BASE_SWITCH_IN};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // Synchronised strap fields
    assign base_sel = strap_sync_reg[STRAP_SEL_LSB +: SEL_W];
    assign wait_en = strap_sync_reg[STRAP_WAIT];
    assign zero_mode = strap_sync_reg[STRAP_ZERO];
    assign simul_pair = strap_sync_reg[STRAP_PAIR_LSB +: NUM_PAIR];

    // Bus decode of the current transfer
    assign setup = PSEL_IN && !PENABLE_IN;
    assign done = PSEL_IN && PENABLE_IN && (phase_reg == SCDLUC_ANSWER);
    assign idx = PADDR_IN[IDX_LSB +: IDX_W];
    assign bus_hit = in_window(PADDR_IN, base_sel);
    assign wr_lo_byte = PWRITE_IN && PSTRB_IN[0];
    assign upd_rd = done && bus_hit && !PWRITE_IN && (idx <= UPD_LAST_IDX);
    assign any_hi_wr = |hi_wr;

    // Answer phase: one wait state only for board accesses when strapped
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            phase_reg <= SCDLUC_IDLE;
        end else begin
            case (phase_reg)
                SCDLUC_WAIT: begin
                    phase_reg <= SCDLUC_ANSWER;
                end
                default: begin
                    if (setup) begin
                        phase_reg <= (bus_hit && wait_en) ? SCDLUC_WAIT : SCDLUC_ANSWER;
                    end else begin
                        phase_reg <= SCDLUC_IDLE;
                    end
                end
            endcase
        end
    end

    // Ready flop tracks the answer phase, so the pin comes from a register
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pready_reg <= 1'b0;
        end else begin
            case (phase_reg)
                SCDLUC_WAIT: begin
                    pready_reg <= 1'b1;
                end
                default: begin
                    pready_reg <= setup && !(bus_hit && wait_en);
                end
            endcase
        end
    end

    // Read data and error captured at setup; digital I/O locations read zero
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            prdata_reg <= RDATA_RST;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            pslverr_reg <= !bus_hit;
            prdata_reg <= RDATA_RST;
            if (bus_hit && !PWRITE_IN && (idx <= DAC_LAST_IDX)) begin
                if (idx[0]) begin
                    prdata_reg[HI_W-1:0] <= latched_reg[idx[IDX_W-1:1]][CODE_W-1:LO_W];
                end else begin
                    prdata_reg[LO_W-1:0] <= latched_reg[idx[IDX_W-1:1]][LO_W-1:0];
                end
            end
        end
    end

    assign PREADY_OUT = pready_reg;
    assign PRDATA_OUT = prdata_reg;
    assign PSLVERR_OUT = pslverr_reg;

    // Zero power-up hold: armed by a high write, released by a later read
    assign hold_next = hold_reg && !(armed_reg && upd_rd);
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            hold_reg <= HOLD_RST;
            armed_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            if (any_hi_wr) begin
                armed_reg <= 1'b1;
            end
        end
    end

    // Per-channel double-buffered path
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        localparam logic [IDX_W-1:0] LO_IDX = IDX_W'(CH_STRIDE * g);
        localparam logic [IDX_W-1:0] HI_IDX = IDX_W'(CH_STRIDE * g + 1);
        localparam int PAIR = g / CH_STRIDE;
        logic lo_wr;
        logic [CODE_W-1:0] new_code;

        assign lo_wr = done && bus_hit && wr_lo_byte && (idx == LO_IDX);
        assign hi_wr[g] = done && bus_hit && wr_lo_byte && (idx == HI_IDX);
        assign new_code = {PWDATA_IN[HI_W-1:0], lo_reg[g]};

        // Output stage takes new code per the pair's mode strap
        always_comb begin
            latched_next[g] = latched_reg[g];
            if (!simul_pair[PAIR] && hi_wr[g]) begin
                latched_next[g] = new_code;
            end else if (simul_pair[PAIR] && upd_rd) begin
                latched_next[g] = input_reg[g];
            end
        end

        // Holding bytes and output stage
        always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                lo_reg[g] <= LO_RST;
                input_reg[g] <= CODE_RST;
                latched_reg[g] <= CODE_RST;
                code_out_reg[g] <= CODE_RST;
                load_reg[g] <= 1'b0;
            end else begin
                if (lo_wr) begin
                    lo_reg[g] <= PWDATA_IN[LO_W-1:0];
                end
                if (hi_wr[g]) begin
                    input_reg[g] <= new_code;
                end
                latched_reg[g] <= latched_next[g];
                code_out_reg[g] <= (hold_next && zero_mode) ? CODE_RST : latched_next[g];
                load_reg[g] <= (!simul_pair[PAIR] && hi_wr[g])
                    || (simul_pair[PAIR] && upd_rd);
            end
        end
    end

    assign DAC0_CODE_OUT = code_out_reg[0];
    assign DAC1_CODE_OUT = code_out_reg[1];
    assign DAC2_CODE_OUT = code_out_reg[2];
    assign DAC3_CODE_OUT = code_out_reg[3];
    assign DAC4_CODE_OUT = code_out_reg[4];
    assign DAC5_CODE_OUT = code_out_reg[5];
    assign DAC_LOAD_OUT = load_reg;

    // Checks
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    chk_lo_no_change: assert property (done && bus_hit && PWRITE_IN && idx == 4'h0
        |=> $stable(latched_reg[0]) && !DAC_LOAD_OUT[0])
        else $error("low byte write changed output stage");
    chk_pair_shared: assert property (DAC_LOAD_OUT[0] && simul_pair[0]
        |-> DAC_LOAD_OUT[1])
        else $error("simultaneous pair loaded one channel alone");
    chk_simul_hold_write: assert property (done && bus_hit && PWRITE_IN && simul_pair[0]
        |=> !DAC_LOAD_OUT[0] && !DAC_LOAD_OUT[1])
        else $error("simultaneous pair loaded on a write");
    chk_simul_read_update: assert property (upd_rd && simul_pair[2]
        |=> DAC_LOAD_OUT[4] && DAC_LOAD_OUT[5])
        else $error("read did not update simultaneous pair");
    chk_window_decode: assert property (setup |=> PSLVERR_OUT == $past(bus_hit == 1'b0))
        else $error("window decode answer wrong");
    chk_wait_one_state: assert property (setup && bus_hit && wait_en
        |=> !PREADY_OUT ##1 PREADY_OUT)
        else $error("board access not stretched by one cycle");
    chk_no_stretch_else: assert property (setup && !(bus_hit && wait_en) |=> PREADY_OUT)
        else $error("cycle stretched without cause");
    chk_hold_zero: assert property (hold_next && zero_mode
        |=> (DAC0_CODE_OUT | DAC1_CODE_OUT | DAC2_CODE_OUT | DAC3_CODE_OUT
        | DAC4_CODE_OUT | DAC5_CODE_OUT) == 12'h000)
        else $error("output not zero during power-up hold");
    chk_hold_release: assert property (hold_reg && !armed_reg |=> hold_reg)
        else $error("hold released before a high write");
    chk_hi_nibble: assert property (hi_wr[1] && !simul_pair[0]
        |=> latched_reg[1][CODE_W-1:LO_W] == $past(PWDATA_IN[HI_W-1:0]))
        else $error("high nibble not placed in upper bits");
    chk_digital_reads_zero: assert property (setup && bus_hit && idx > DAC_LAST_IDX
        |=> PRDATA_OUT == 32'h00000000)
        else $error("digital I/O location read nonzero");
    chk_indiv_load: assert property (hi_wr[2] && !simul_pair[1]
        |=> DAC_LOAD_OUT[2] ##1 !DAC_LOAD_OUT[2] || hi_wr[2])
        else $error("individual channel not loaded on high write");

    // Answer and refusal checks
    chk_ready_single: assert property (done |=> !PREADY_OUT)
        else $error("ready held past the completing edge");
    chk_error_no_load: assert property (done && !bus_hit |=> DAC_LOAD_OUT == 6'h00)
        else $error("access outside window loaded a channel");
    chk_strobe_ignored: assert property (done && bus_hit && PWRITE_IN && !PSTRB_IN[0]
        |=> DAC_LOAD_OUT == 6'h00 && $stable(armed_reg))
        else $error("write without low strobe took effect");

    // Holding and output stage checks
    chk_read_low_byte: assert property (setup && bus_hit && !PWRITE_IN && idx == 4'h4
        |=> PRDATA_OUT == {24'h000000, $past(latched_reg[2][LO_W-1:0])})
        else $error("low byte read does not match output stage");
    chk_lo_byte_kept: assert property (done && bus_hit && wr_lo_byte && idx == 4'h2
        |=> lo_reg[1] == $past(PWDATA_IN[LO_W-1:0]))
        else $error("low byte not kept in holding stage");
    chk_simul_fill: assert property (hi_wr[0] && simul_pair[0]
        |=> input_reg[0] == {$past(PWDATA_IN[HI_W-1:0]), $past(lo_reg[0])}
        && $stable(latched_reg[0]))
        else $error("simultaneous write did not only fill holding stage");
    chk_upd_range: assert property (done && bus_hit && !PWRITE_IN && idx > UPD_LAST_IDX
        |=> DAC_LOAD_OUT == 6'h00)
        else $error("read above last update offset loaded a channel");
    chk_indiv_code: assert property (hi_wr[3] && !simul_pair[1]
        && !(hold_next && zero_mode)
        |=> DAC3_CODE_OUT == {$past(PWDATA_IN[HI_W-1:0]), $past(lo_reg[3])})
        else $error("individual channel code not shown after high write");
    chk_load_on_done: assert property (!done |=> DAC_LOAD_OUT == 6'h00)
        else $error("load strobe without a completed access");
    chk_armed_stays: assert property (armed_reg |=> armed_reg)
        else $error("hold armed state lost before reset");
    chk_standard_direct: assert property (!zero_mode
        |=> DAC0_CODE_OUT == latched_reg[0])
        else $error("standard mode output differs from output stage");

    // Main scenarios
    cov_wait_access: cover property (setup && bus_hit && wait_en ##2 done);
    cov_simul_update: cover property (upd_rd && simul_pair == 3'h7);
    cov_hold_release: cover property (hold_reg && zero_mode ##1 !hold_reg);
    cov_indiv_load: cover property (hi_wr[0] && !simul_pair[0]);
    cov_error_access: cover property (done && !bus_hit);
endmodule

// file: test/scdluc_host.sv
`timescale 1ns/1ps
// Host model, one bus transfer per call
module scdluc_host (
    input wire logic clk_in, // Clock
    input wire logic [31:0] prdata_in, // Read data
    input wire logic pready_in, // Ready
    input wire logic pslverr_in, // Error
    output logic psel_out, // Select
    output logic penable_out, // Enable
    output logic pwrite_out, // Direction
    output logic [31:0] paddr_out, // Address
    output logic [31:0] pwdata_out, // Write data
    output logic [3:0] pstrb_out // Strobes
);
    // Idle bus from time zero
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 32'h0;
        pwdata_out = 32'h0;
        pstrb_out = 4'h0;
    end
    // Setup, access until ready, release with address and data inverted
    task automatic transfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic er, output int n);
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        pstrb_out <= s;
        n = 0;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 50);
        rd = prdata_in;
        er = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask
endmodule

// file: test/tb_scdluc_top.sv
`timescale 1ns/1ps
// Bench for the six-channel load and update block
module tb_scdluc_top;
    import scdluc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, er, hold, armed;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic wait_en = 1'b0;
    logic zero = 1'b1;
    logic [SEL_W-1:0] base = FACTORY_BASE_SEL;
    logic [NUM_PAIR-1:0] simul = 3'h5;
    logic [NUM_CH-1:0] load, m;
    logic [CODE_W-1:0] code [NUM_CH];
    logic [CODE_W-1:0] exp_c [NUM_CH];
    logic [CODE_W-1:0] hold_c [NUM_CH];
    logic [77:0] q [$];
    int fail_count = 0;
    int cmp_count = 0;
    int nw;
    integer seed = 32'h52FF3ED2;
    // Clock
    always #12.5 clk = ~clk;
    scdluc_host host (.clk_in(clk), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));
    scdluc_top DUT (.CLOCK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .BASE_SWITCH_IN(base), .WAIT_EN_IN(wait_en), .ZERO_POWERUP_IN(zero),
        .SIMUL_PAIR_IN(simul), .DAC0_CODE_OUT(code[0]), .DAC1_CODE_OUT(code[1]),
        .DAC2_CODE_OUT(code[2]), .DAC3_CODE_OUT(code[3]), .DAC4_CODE_OUT(code[4]),
        .DAC5_CODE_OUT(code[5]), .DAC_LOAD_OUT(load));
    task automatic cmp_ld(input logic [77:0] got, input logic [77:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    // Expected load mask and visible codes
    function automatic logic [77:0] snap(input logic [NUM_CH-1:0] mk);
        logic [77:0] r;
        r = {mk, 72'h0};
        for (int i = 0; i < NUM_CH; i++) if (!(hold && zero)) r[i*CODE_W +: CODE_W] = exp_c[i];
        return r;
    endfunction
    task automatic reinit();
        hold = 1'b1;
        armed = 1'b0;
        for (int c = 0; c < NUM_CH; c++) exp_c[c] = CODE_RST;
        for (int c = 0; c < NUM_CH; c++) hold_c[c] = CODE_RST;
    endtask
    task automatic acc(input logic w, input logic [3:0] i, input logic [31:0] d,
        input logic [3:0] s, input logic hit);
        host.transfer(w, {20'h0, (hit ? base : ~base), i, 2'b00}, d, s, rd, er, nw);
        cmp_rd(33'(nw), (hit && wait_en) ? 33'h2 : 33'h1); // Wait count
    endtask
    task automatic load_ch(input int ch);
        logic [31:0] lo, hi;
        lo = $random(seed);
        hi = $random(seed);
        acc(1'b1, 4'(ch * 2), lo, 4'h1, 1'b1); // Low first
        acc(1'b1, 4'(ch * 2 + 1), hi, 4'h1, 1'b1); // High second
        armed = 1'b1;
        if (simul[ch / 2]) hold_c[ch] = {hi[3:0], lo[7:0]}; // Holding only
        else begin
            exp_c[ch] = {hi[3:0], lo[7:0]};
            q.push_back(snap(6'h01 << ch)); // Load on high write
        end
    endtask
    task automatic upd(input logic [3:0] i);
        logic [32:0] e;
        e = (i > DAC_LAST_IDX) ? 33'h0 :
            {25'h0, (i[0] ? {4'h0, exp_c[i/2][11:8]} : exp_c[i/2][7:0])};
        acc(1'b0, i, 32'h0, 4'h0, 1'b1); // Read in window
        cmp_rd({er, rd}, e); // Read data
        if (i <= UPD_LAST_IDX) begin
            if (armed) hold = 1'b0; // Release
            m = {{2{simul[2]}}, {2{simul[1]}}, {2{simul[0]}}}; // Pairs
            for (int c = 0; c < NUM_CH; c++) if (m[c]) exp_c[c] = hold_c[c];
            if (m != 6'h00) q.push_back(snap(m)); // Update on read
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Each load pulse against the oldest note
    always @(posedge clk) begin
        if (rstn === 1'b1 && load !== 6'h00) begin
            cmp_ld({load, code[5], code[4], code[3], code[2], code[1], code[0]},
                (q.size() != 0) ? q.pop_front() : 78'h0); // Loads
        end
    end
    // Main sequence
    initial begin
        reinit();
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        upd(4'h0); // Not armed, hold stays
        for (int c = 0; c < NUM_CH; c++) load_ch((c + 2) % NUM_CH);
        acc(1'b0, 4'h4, 32'h0, 4'h0, 1'b0);
        cmp_rd({er, rd}, {1'b1, 32'h0}); // Outside window
        acc(1'b1, 4'h5, 32'hFFFFFFFF, 4'h1, 1'b0); // Ignored outside
        acc(1'b1, 4'h5, 32'hFFFFFFFF, 4'hE, 1'b1); // Low strobe off, ignored
        upd(4'hD); // No update
        upd(4'h5); // Release and update
        upd(4'hC); // Last update offset
        wait_en <= 1'b1;
        repeat (3) @(posedge clk);
        load_ch(3); // With wait state
        acc(1'b0, 4'h0, 32'h0, 4'h0, 1'b0); // Not stretched outside
        cmp_rd({er, rd}, {1'b1, 32'h0}); // Outside window
        upd(4'hB); // Update on high offset
        // Let the last update pulse be checked before reset clears it
        @(posedge clk);
        rstn <= 1'b0;
        zero <= 1'b0;
        simul <= 3'($random(seed)) & 3'h6; // Pair 0 individual, others random
        base <= 6'($random(seed));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        reinit();
        repeat (3) @(posedge clk);
        for (int c = 0; c < NUM_CH; c++) load_ch(c);
        for (int i = 0; i < 16; i++) upd(4'(i));
        repeat (4) @(posedge clk);
        if (q.size() != 0) fail_count++;
        end_of_test();
    end
    // Watchdog
    initial begin
        #(25 * 20000);
        fail_count++;
        end_of_test();
    end
endmodule
